// ===== media_ops.sv
// Packed media execution datapath with its own eight-entry 64-bit register file.
// Assumes the decoder issues one request at a time and waits while busy is high.
`timescale 1ns/10ps
`default_nettype none
module media_ops
   import media_ops_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire media_ops_pkg::req_t    req,
   output var  media_ops_pkg::result_t res,
   output logic                        busy
);
   import media_ops_pkg::*;

   typedef struct packed {
      stage_t                              stage;
      logic [REG_N-1:0][DATA_W-1:0]        regs;
      result_t                             pend;
      result_t                             res;
      logic                                busy;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   logic [REG_W-1:0]  imp_reg;
   logic [DATA_W-1:0] dval;
   logic [DATA_W-1:0] sval;
   logic [DATA_W-1:0] ival;
   logic [DATA_W-1:0] mag_res;
   logic [DATA_W-1:0] mul_dst_res;
   logic [DATA_W-1:0] sub_res;
   logic [DATA_W-1:0] ge_res;
   logic [DATA_W-1:0] lz_res;
   logic [DATA_W-1:0] nz_res;
   logic [DATA_W-1:0] z_res;
   logic              is_cond_move;
   logic              is_two_clk;
   logic              op_known;

   assign imp_reg = req.dst ^ IMPLIED_FLIP;
   assign dval    = st_r.regs[req.dst];
   assign sval    = req.use_mem ? req.mem_data : st_r.regs[req.src];
   assign ival    = st_r.regs[imp_reg];

   genvar gi;
   generate
      for (gi = 0; gi < WORD_N; gi++) begin : g_word
         logic [15:0] dw;
         logic [15:0] sw;
         logic [16:0] dabs;
         logic [16:0] sabs;
         logic [16:0] diff;
         assign dw   = dval[gi*16 +: 16];
         assign sw   = sval[gi*16 +: 16];
         assign dabs = dw[15] ? 17'(-$signed({dw[15], dw})) : {1'b0, dw};
         assign sabs = sw[15] ? 17'(-$signed({sw[15], sw})) : {1'b0, sw};
         // Ties keep the destination lane
         assign mag_res[gi*16 +: 16] = (sabs > dabs) ? sw : dw;
         mul_round_lane u_mul (
            .a (dw),
            .b (sw),
            .y (mul_dst_res[gi*16 +: 16])
         );
         assign diff = {dw[15], dw} - {sw[15], sw};
         // Clamp when the 17-bit difference leaves the 16-bit range
         assign sub_res[gi*16 +: 16] = (diff[16] == diff[15]) ? diff[15:0] :
                                       (diff[16] ? SAT_MIN : SAT_MAX);
      end

      for (gi = 0; gi < BYTE_N; gi++) begin : g_byte
         logic [7:0] ib;
         logic [7:0] db;
         logic [7:0] mb;
         assign ib = ival[gi*8 +: 8];
         assign db = dval[gi*8 +: 8];
         assign mb = req.mem_data[gi*8 +: 8];
         assign ge_res[gi*8 +: 8] = !ib[7] ? mb : db;
         assign lz_res[gi*8 +: 8] = ib[7] ? mb : db;
         assign nz_res[gi*8 +: 8] = (ib != BYTE_ZERO) ? mb : db;
         assign z_res[gi*8 +: 8]  = (ib == BYTE_ZERO) ? mb : db;
      end
   endgenerate

   // Opcode classes that steer sequencing and rejects
   always_comb begin
      is_cond_move = 1'b0;
      is_two_clk   = 1'b0;
      op_known     = 1'b1;
      if (req.op == OP_LARGEST_MAGNITUDE_WORD) begin
         is_two_clk = 1'b1;
      end else if (req.op == OP_MUL_HIGH_ROUND) begin
         is_two_clk = 1'b1;
      end else if (req.op == OP_MUL_HIGH_ROUND_IMPLIED) begin
         is_two_clk = 1'b1;
      end else if (req.op == OP_COND_MOVE_NONNEG_BYTE) begin
         is_cond_move = 1'b1;
      end else if (req.op == OP_COND_MOVE_NEG_BYTE) begin
         is_cond_move = 1'b1;
      end else if (req.op == OP_COND_MOVE_NONZERO_BYTE) begin
         is_cond_move = 1'b1;
      end else if (req.op == OP_COND_MOVE_ZERO_BYTE) begin
         is_cond_move = 1'b1;
      end else if (req.op == OP_SAT_SUB_IMPLIED_WORD) begin
         op_known = 1'b1;
      end else if (req.op == OP_LOAD_REG) begin
         op_known = 1'b1;
      end else begin
         op_known = 1'b0;
      end
   end

   always_comb begin
      st_nxt           = st_r;
      st_nxt.res.valid = 1'b0;
      st_nxt.res.ill   = 1'b0;
      case (st_r.stage)
         S_IDLE: begin
            if (req.valid) begin
               st_nxt.pend.valid = 1'b1;
               st_nxt.pend.ill   = 1'b0;
               st_nxt.pend.dst   = req.dst;
               st_nxt.pend.data  = DATA_ZERO;
               case (req.op)
                  OP_LARGEST_MAGNITUDE_WORD: begin
                     st_nxt.pend.data = mag_res;
                  end
                  OP_MUL_HIGH_ROUND: begin
                     st_nxt.pend.data = mul_dst_res;
                  end
                  OP_MUL_HIGH_ROUND_IMPLIED: begin
                     st_nxt.pend.data = mul_dst_res;
                     st_nxt.pend.dst  = imp_reg;
                  end
                  OP_COND_MOVE_NONNEG_BYTE: begin
                     st_nxt.pend.data = ge_res;
                  end
                  OP_COND_MOVE_NEG_BYTE: begin
                     st_nxt.pend.data = lz_res;
                  end
                  OP_COND_MOVE_NONZERO_BYTE: begin
                     st_nxt.pend.data = nz_res;
                  end
                  OP_COND_MOVE_ZERO_BYTE: begin
                     st_nxt.pend.data = z_res;
                  end
                  OP_SAT_SUB_IMPLIED_WORD: begin
                     st_nxt.pend.data = sub_res;
                     st_nxt.pend.dst  = imp_reg;
                  end
                  OP_LOAD_REG: begin
                     st_nxt.pend.data = sval;
                  end
                  default: begin
                     st_nxt.pend.valid = 1'b0;
                     st_nxt.pend.ill   = 1'b1;
                  end
               endcase

               // Unknown opcodes and register-form moves are rejected
               if (!op_known || (!req.use_mem && is_cond_move)) begin
                  st_nxt.pend.valid = 1'b0;
                  st_nxt.pend.ill   = 1'b1;
               end

               if (st_nxt.pend.valid && is_two_clk) begin
                  // Two-clock operations finish in the next stage
                  st_nxt.stage = S_EXEC2;
                  st_nxt.busy  = 1'b1;
               end else begin
                  st_nxt.res.valid = st_nxt.pend.valid;
                  st_nxt.res.ill   = st_nxt.pend.ill;
                  // Rejects leave the last written register on the result port
                  if (st_nxt.pend.valid) begin
                     st_nxt.res.dst               = st_nxt.pend.dst;
                     st_nxt.res.data              = st_nxt.pend.data;
                     st_nxt.regs[st_nxt.pend.dst] = st_nxt.pend.data;
                  end
               end
            end
         end
         S_EXEC2: begin
            // Second clock retires the held result
            st_nxt.res.valid           = 1'b1;
            st_nxt.res.ill             = 1'b0;
            st_nxt.res.dst             = st_r.pend.dst;
            st_nxt.res.data            = st_r.pend.data;
            st_nxt.regs[st_r.pend.dst] = st_r.pend.data;
            st_nxt.pend.valid          = 1'b0;
            st_nxt.stage               = S_IDLE;
            st_nxt.busy                = 1'b0;
         end
         default: begin
            st_nxt.stage = S_IDLE;
            st_nxt.busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign res  = st_r.res;
   assign busy = st_r.busy;
endmodule
`default_nettype wire

// ===== media_ops_pkg.sv
// Constants, opcodes and carrier types for the packed media datapath.
// Assumes a single core clock domain; opcodes arrive already decoded.
package media_ops_pkg;
   localparam int          REG_N        = 8;
   localparam int          REG_W        = 3;
   localparam int          DATA_W       = 64;
   localparam int          WORD_N       = 4;
   localparam int          BYTE_N       = 8;
   localparam logic [15:0] OP_LARGEST_MAGNITUDE_WORD = 16'h0F52;
   localparam logic [15:0] OP_MUL_HIGH_ROUND_IMPLIED = 16'h0F5D;
   localparam logic [15:0] OP_MUL_HIGH_ROUND         = 16'h0F59;
   localparam logic [15:0] OP_COND_MOVE_NONNEG_BYTE  = 16'h0F5C;
   localparam logic [15:0] OP_COND_MOVE_NEG_BYTE     = 16'h0F5B;
   localparam logic [15:0] OP_COND_MOVE_NONZERO_BYTE = 16'h0F5A;
   localparam logic [15:0] OP_COND_MOVE_ZERO_BYTE    = 16'h0F58;
   localparam logic [15:0] OP_SAT_SUB_IMPLIED_WORD   = 16'h0F55;
   localparam logic [15:0] OP_LOAD_REG               = 16'h0FFF;
   localparam logic [2:0]  IMPLIED_FLIP = 3'h1;
   localparam logic [31:0] ROUND_HALF   = 32'h0000_4000;
   localparam int          PROD_HI      = 30;
   localparam int          PROD_LO      = 15;
   localparam logic [15:0] SAT_MAX      = 16'h7FFF;
   localparam logic [15:0] SAT_MIN      = 16'h8000;
   localparam logic [7:0]  BYTE_ZERO    = 8'h00;
   localparam logic [63:0] DATA_ZERO    = 64'h0000_0000_0000_0000;

   typedef enum logic {S_IDLE, S_EXEC2} stage_t;

   typedef struct packed {
      logic              valid;
      logic [15:0]       op;
      logic [REG_W-1:0]  dst;
      logic [REG_W-1:0]  src;
      logic              use_mem;
      logic [DATA_W-1:0] mem_data;
   } req_t;

   typedef struct packed {
      logic              valid;
      logic              ill;
      logic [REG_W-1:0]  dst;
      logic [DATA_W-1:0] data;
   } result_t;
endpackage

// ===== mul_round_lane.sv
// One signed 16x16 word lane multiply with rounding, product bits 30:15 out.
// Pure combinational; instantiated per word lane by the datapath.
`timescale 1ns/10ps
`default_nettype none
module mul_round_lane
   import media_ops_pkg::*;
(
   input  wire logic [15:0] a,
   input  wire logic [15:0] b,
   output logic      [15:0] y
);
   logic signed [31:0] prod;
   logic        [31:0] sum;

   always_comb begin
      prod = $signed(a) * $signed(b);
      sum  = 32'(prod) + ROUND_HALF;
      y    = sum[PROD_HI:PROD_LO];
   end
endmodule
`default_nettype wire

// ===== media_ops_assertions.sv
// Port-level checker for the packed media datapath.
// Assumes the single core clock and active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module media_ops_assertions
   import media_ops_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    nrst,
   input wire media_ops_pkg::req_t     req,
   input wire media_ops_pkg::result_t  res,
   input wire logic                    busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic tk;
   assign tk = req.valid && !busy;
   sequence two_clk(logic [2:0] d);
      (busy && !res.valid) ##1 (res.valid && !busy && res.dst == d);
   endsequence
   sequence one_clk(logic [2:0] d);
      res.valid && !busy && res.dst == d;
   endsequence
   magnitude_two_clk_a: assert property (tk && req.op == OP_LARGEST_MAGNITUDE_WORD
      |=> two_clk($past(req.dst, 2))) else $error("magnitude result timing");
   mul_implied_a: assert property (tk && req.op == OP_MUL_HIGH_ROUND_IMPLIED
      |=> two_clk($past(req.dst, 2) ^ IMPLIED_FLIP)) else $error("implied multiply");
   mul_named_a: assert property (tk && req.op == OP_MUL_HIGH_ROUND
      |=> two_clk($past(req.dst, 2))) else $error("named multiply");
   nonneg_move_a: assert property (tk && req.use_mem && req.op == OP_COND_MOVE_NONNEG_BYTE
      |=> one_clk($past(req.dst))) else $error("nonnegative move");
   neg_move_a: assert property (tk && req.use_mem && req.op == OP_COND_MOVE_NEG_BYTE
      |=> one_clk($past(req.dst))) else $error("negative move");
   nonzero_move_a: assert property (tk && req.use_mem && req.op == OP_COND_MOVE_NONZERO_BYTE
      |=> one_clk($past(req.dst))) else $error("nonzero move");
   zero_move_a: assert property (tk && req.use_mem && req.op == OP_COND_MOVE_ZERO_BYTE
      |=> one_clk($past(req.dst))) else $error("zero move");
   sat_sub_a: assert property (tk && req.op == OP_SAT_SUB_IMPLIED_WORD
      |=> one_clk($past(req.dst) ^ IMPLIED_FLIP) ##1 !res.valid) else $error("sat subtract");
endmodule
bind media_ops media_ops_assertions i_chk (.clk(clk), .nrst(nrst), .req(req), .res(res),
   .busy(busy));
`default_nettype wire

// ===== decoder_model.sv
// Decoder-side model issuing one request at a time.
// Assumes requests are changed at the falling edge only.
`timescale 1ns/10ps
`default_nettype none
module decoder_model
   import media_ops_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           busy,
   output var media_ops_pkg::req_t req
);
   initial req = '0;
   task automatic issue(input logic [15:0] op, input int d, s, input logic um,
                        input logic [63:0] m);
      @(negedge clk);
      while (busy) @(negedge clk);
      req = '{1'b1, op, 3'(d), 3'(s), um, m};
      @(posedge clk);
      @(negedge clk);
      // Released operand no longer shows old data
      req = '{1'b0, op, 3'(d), 3'(s), um, ~m};
   endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the packed media datapath.
// Assumes decoder_model drives requests; results checked against a lane model.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import media_ops_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        busy;
   req_t        req;
   result_t     res;
   int          fails = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          i;
   logic [63:0] mdl [8];
   logic [15:0] ops [10] = '{OP_LARGEST_MAGNITUDE_WORD, OP_MUL_HIGH_ROUND_IMPLIED,
      OP_MUL_HIGH_ROUND, OP_COND_MOVE_NONNEG_BYTE, OP_COND_MOVE_NEG_BYTE,
      OP_COND_MOVE_NONZERO_BYTE, OP_COND_MOVE_ZERO_BYTE, OP_SAT_SUB_IMPLIED_WORD,
      OP_LOAD_REG, 16'h0F53};
   initial forever #12.5 clk = ~clk;
   media_ops i_dut (.clk(clk), .nrst(nrst), .req(req), .res(res), .busy(busy));
   decoder_model i_dec (.clk(clk), .busy(busy), .req(req));
   task automatic end_sim;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic run(input logic [15:0] op, input int d, s, input logic um,
                      input logic [63:0] m);
      logic [63:0] a, b, ia, e;
      logic [2:0]  ed;
      logic        bad;
      logic        miss;
      int          x, y, z, k;
      a  = mdl[d];
      b  = um ? m : mdl[s];
      ia = mdl[d ^ 1];
      e  = a;
      ed = 3'(d);
      for (k = 0; k < 4; k++) begin
         x = $signed(a[16*k +: 16]);
         y = $signed(b[16*k +: 16]);
         z = x - y;
         z = (z > 32767) ? 32767 : (z < -32768) ? -32768 : z;
         case (op)
            OP_LARGEST_MAGNITUDE_WORD: begin
               if ((y < 0 ? -y : y) > (x < 0 ? -x : x)) e[16*k +: 16] = 16'(y);
            end
            OP_MUL_HIGH_ROUND, OP_MUL_HIGH_ROUND_IMPLIED: begin
               e[16*k +: 16] = 16'((x * y + 16384) >>> 15);
            end
            OP_SAT_SUB_IMPLIED_WORD: e[16*k +: 16] = 16'(z);
            OP_LOAD_REG: e = b;
            default: ;
         endcase
      end
      for (k = 0; k < 8; k++) begin
         x = $signed(ia[8*k +: 8]);
         if ((op == OP_COND_MOVE_NONNEG_BYTE && x >= 0) || (op == OP_COND_MOVE_NEG_BYTE && x < 0)
             || (op == OP_COND_MOVE_NONZERO_BYTE && x != 0)
             || (op == OP_COND_MOVE_ZERO_BYTE && x == 0))
            e[8*k +: 8] = m[8*k +: 8];
      end
      if (op inside {OP_MUL_HIGH_ROUND_IMPLIED, OP_SAT_SUB_IMPLIED_WORD}) ed = 3'(d ^ 1);
      bad = (op == 16'h0F53) || (!um && op inside {OP_COND_MOVE_NONNEG_BYTE,
         OP_COND_MOVE_NEG_BYTE, OP_COND_MOVE_NONZERO_BYTE, OP_COND_MOVE_ZERO_BYTE});
      i_dec.issue(op, d, s, um, m);
      for (k = 0; k < 4 && !(res.valid === 1'b1 || res.ill === 1'b1); k++) @(negedge clk);
      total_checks++;
      miss = bad ? (res.ill !== 1'b1) : (res.valid !== 1'b1 || res.dst !== ed);
      if (miss || (!bad && res.data !== e)) begin
         fails++;
         $display("unexpected t=%0t op %h dst %0d", $time, op, d);
      end
      if (!bad) mdl[ed] = e;
   endtask
   task automatic run_rand(input int n);
      logic [15:0] op;
      logic [63:0] m;
      int          j, d, s;
      logic        um;
      for (j = 0; j < n; j++) begin
         op = ops[$urandom % 10];
         d  = $urandom % 8;
         s  = $urandom % 8;
         um = ($urandom % 6) != 0;
         m  = {$urandom, $urandom};
         if ($urandom % 3 == 0) m = 64'h8000_7FFF_0080_FF01;
         run(op, d, s, um, m);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         $display("unexpected t=%0t timeout", $time);
         end_sim;
      end
   end
   initial begin
      void'($urandom(33));
      for (i = 0; i < 8; i++) mdl[i] = '0;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      for (i = 0; i < 8; i++) run(OP_LOAD_REG, i, 0, 1'b1, {$urandom, $urandom});
      $display("test load done");
      run_rand(300);
      $display("test random done");
      // Mid-run reset must clear every register
      nrst = 1'b0;
      @(negedge clk);
      nrst = 1'b1;
      for (i = 0; i < 8; i++) mdl[i] = '0;
      run_rand(20);
      $display("test reset done");
      end_sim;
   end
endmodule
`default_nettype wire
